// >>> verilog/hfqa_pkg.sv
// constants and types shared by the host frame queue access block
package hfqa_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int PTR_W = 11;
    // register offsets, byte addresses
    localparam logic [3:0] OFS_TX_ENQ = 4'h0;
    localparam logic [3:0] OFS_RX_REL = 4'h2;
    localparam logic [3:0] OFS_TX_PTR = 4'h4;
    localparam logic [3:0] OFS_RX_PTR = 4'h6;
    localparam logic [3:0] OFS_QDATA = 4'h8;
    // field positions
    localparam int CMD_BIT = 0;
    localparam int AUTO_INC_BIT = 14;
    // values after reset
    localparam logic [10:0] PTR_RESET = 11'h000;
    localparam logic AUTO_INC_RESET = 1'h0;
    localparam logic CMD_RESET = 1'h0;
    // access sizes on the queue data register
    typedef enum logic [1:0] {
        HFQA_SZ_BYTE = 2'b00,
        HFQA_SZ_WORD = 2'b01,
        HFQA_SZ_DWORD = 2'b10
    } hfqa_size_type;
    // command sequencer states
    typedef enum logic [1:0] {
        HFQA_IDLE = 2'b00,
        HFQA_REQ = 2'b01,
        HFQA_WAIT = 2'b10
    } hfqa_cmd_state_type;
endpackage

// >>> verilog/hfqa_cmd_seq.sv
// self-clearing command sequencer: issues a request, waits for done
`timescale 1ns/10ps
module hfqa_cmd_seq
    import hfqa_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // software start and status
    input wire logic start,
    output logic busy,
    // datapath handshake
    output logic req,
    input wire logic ack,
    input wire logic done
);
    typedef struct packed {
        hfqa_cmd_state_type st;
        logic busy;
        logic req;
    } hfqa_seq_type;
    hfqa_seq_type s_q, s_d;

    // request held until taken, then wait for completion
    always_comb begin
        s_d = s_q;
        case (s_q.st)
            HFQA_IDLE: begin
                if (start) begin
                    s_d.st = HFQA_REQ;
                end
            end
            HFQA_REQ: begin
                if (ack) begin
                    s_d.st = done ? HFQA_IDLE : HFQA_WAIT;
                end
            end
            HFQA_WAIT: begin
                if (done) begin
                    s_d.st = HFQA_IDLE;
                end
            end
            default: begin
                s_d.st = HFQA_IDLE;
            end
        endcase
        // flags registered with the state so the outputs come from flops
        s_d.busy = (s_d.st != HFQA_IDLE);
        s_d.req = (s_d.st == HFQA_REQ);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{st: HFQA_IDLE, busy: CMD_RESET, req: CMD_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;
    assign req = s_q.req;
endmodule

// >>> verilog/hfqa_skid.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module hfqa_skid
    import hfqa_pkg::*;
#(
    parameter int WIDTH = 48
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic rd;
        logic wr;
        logic [1:0] cnt;
    } hfqa_buf_type;
    hfqa_buf_type b_q, b_d;
    logic push, pop;

    // full at two entries, so the source sees back-pressure
    always_comb begin
        b_d = b_q;
        push = in_valid && (b_q.cnt != 2'h2);
        pop = (b_q.cnt != 2'h0) && out_ready;
        if (push) begin
            b_d.mem[b_q.wr] = in_data;
            b_d.wr = ~b_q.wr;
        end
        if (pop) begin
            b_d.rd = ~b_q.rd;
        end
        b_d.cnt = 2'(b_q.cnt + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            b_q <= '0;
        end else begin
            b_q <= b_d;
        end
    end

    assign in_ready = (b_q.cnt != 2'h2);
    assign out_valid = (b_q.cnt != 2'h0);
    assign out_data = b_q.mem[b_q.rd];
endmodule

// >>> verilog/hfqa_top.sv
// host frame queue access: command bits, byte pointers and data routing
// Function
// - writing enqueue bit queues assembled tx frame
// - enqueue bit self-clears after transmit completes
// - writing release bit frees current rx frame
// - release bit self-clears once memory freed
// - tx auto-increment advances pointer by access size
// - without auto-increment tx pointer holds
// - tx pointer is 11 bits, resets zero
// - tx pointer reloads after enqueue
// - rx auto-increment advances pointer on reads
// - without auto-increment rx pointer holds
// - rx pointer is 11 bits, resets zero
// - rx pointer reloads on release
// - data reads rx queue, writes tx queue
// - mixed access sizes accepted at any alignment
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
module hfqa_top
    import hfqa_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // register port
    input wire logic [hfqa_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [hfqa_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [1:0] REG_SIZE,
    output logic [hfqa_pkg::DATA_W-1:0] REG_RDATA,
    // transmit queue write stream
    output logic TXQ_VALID,
    input wire logic TXQ_READY,
    output logic [hfqa_pkg::PTR_W-1:0] TXQ_ADDR,
    output logic [hfqa_pkg::DATA_W-1:0] TXQ_DATA,
    output logic [1:0] TXQ_SIZE,
    output logic TXQ_STALL,
    // receive queue read port, data combinational on address
    output logic [hfqa_pkg::PTR_W-1:0] RXQ_ADDR,
    input wire logic [hfqa_pkg::DATA_W-1:0] RXQ_RDATA,
    // queue manager handshakes
    output logic TX_ENQ_REQ,
    input wire logic TX_ENQ_ACK,
    input wire logic TX_DONE,
    input wire logic [hfqa_pkg::PTR_W-1:0] TX_NEXT_PTR,
    output logic RX_REL_REQ,
    input wire logic RX_REL_ACK,
    input wire logic RX_FREED,
    input wire logic [hfqa_pkg::PTR_W-1:0] RX_NEXT_PTR
);
    typedef struct packed {
        logic [PTR_W-1:0] tx_ptr;
        logic [PTR_W-1:0] rx_ptr;
        logic tx_ai;
        logic rx_ai;
        logic [DATA_W-1:0] rdata;
        logic [PTR_W-1:0] rxq_addr;
    } hfqa_state_type;
    hfqa_state_type s_q, s_d;

    logic wr_tx_enq, wr_rx_rel, wr_tx_ptr, wr_rx_ptr, wr_data, rd_data;
    logic tx_busy, rx_busy, tx_req, rx_req;
    logic buf_in_ready;
    logic [PTR_W+DATA_W+1:0] buf_out;

    // byte count of one data access; size code 3 treated as a doubleword
    function automatic logic [PTR_W-1:0] step_of(input logic [1:0] sz);
        case (sz)
            HFQA_SZ_BYTE: step_of = 11'h001;
            HFQA_SZ_WORD: step_of = 11'h002;
            default: step_of = 11'h004;
        endcase
    endfunction

    // address decode
    assign wr_tx_enq = REG_WR && (REG_ADDR == OFS_TX_ENQ);
    assign wr_rx_rel = REG_WR && (REG_ADDR == OFS_RX_REL);
    assign wr_tx_ptr = REG_WR && (REG_ADDR == OFS_TX_PTR);
    assign wr_rx_ptr = REG_WR && (REG_ADDR == OFS_RX_PTR);
    // a data write is refused while the tx buffer is full
    assign wr_data = REG_WR && (REG_ADDR == OFS_QDATA) && buf_in_ready;
    assign rd_data = REG_RD && (REG_ADDR == OFS_QDATA);

    // enqueue command: bit stays set until the frame has gone out
    hfqa_cmd_seq u_tx_cmd (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .start(wr_tx_enq && REG_WDATA[CMD_BIT]),
        .busy(tx_busy),
        .req(tx_req),
        .ack(TX_ENQ_ACK),
        .done(TX_DONE)
    );

    // release command: bit stays set until memory is freed
    hfqa_cmd_seq u_rx_cmd (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .start(wr_rx_rel && REG_WDATA[CMD_BIT]),
        .busy(rx_busy),
        .req(rx_req),
        .ack(RX_REL_ACK),
        .done(RX_FREED)
    );

    // write data lands in the tx queue through a two-entry buffer,
    // so a stalled queue memory loses no word until two are held; a further write is refused
    hfqa_skid #(
        .WIDTH(PTR_W + DATA_W + 2)
    ) u_tx_buf (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .in_valid(REG_WR && (REG_ADDR == OFS_QDATA)),
        .in_ready(buf_in_ready),
        .in_data({REG_SIZE, s_q.tx_ptr, REG_WDATA}),
        .out_valid(TXQ_VALID),
        .out_ready(TXQ_READY),
        .out_data(buf_out)
    );
    assign TXQ_DATA = buf_out[DATA_W-1:0];
    assign TXQ_ADDR = buf_out[PTR_W+DATA_W-1:DATA_W];
    assign TXQ_SIZE = buf_out[PTR_W+DATA_W+1:PTR_W+DATA_W];

    // register and pointer next state
    always_comb begin
        s_d = s_q;
        // tx pointer: host write, auto step, or reload after enqueue
        if (wr_tx_ptr) begin
            s_d.tx_ptr = REG_WDATA[PTR_W-1:0];
            s_d.tx_ai = REG_WDATA[AUTO_INC_BIT];
        end else if (tx_req && TX_ENQ_ACK) begin
            s_d.tx_ptr = TX_NEXT_PTR;
        end else if (wr_data && s_q.tx_ai) begin
            s_d.tx_ptr = PTR_W'(s_q.tx_ptr + step_of(REG_SIZE));
        end
        // rx pointer: host write, auto step on reads, or reload on release
        if (wr_rx_ptr) begin
            s_d.rx_ptr = REG_WDATA[PTR_W-1:0];
            s_d.rx_ai = REG_WDATA[AUTO_INC_BIT];
        end else if (rx_req && RX_REL_ACK) begin
            s_d.rx_ptr = RX_NEXT_PTR;
        end else if (rd_data && s_q.rx_ai) begin
            s_d.rx_ptr = PTR_W'(s_q.rx_ptr + step_of(REG_SIZE));
        end
        s_d.rxq_addr = s_d.rx_ptr;
        // read data; reserved bits stay zero
        s_d.rdata = '0;
        if (REG_RD) begin
            case (REG_ADDR)
                OFS_TX_ENQ: s_d.rdata[CMD_BIT] = tx_busy;
                OFS_RX_REL: s_d.rdata[CMD_BIT] = rx_busy;
                OFS_TX_PTR: s_d.rdata = {17'h0, s_q.tx_ai, 3'h0, s_q.tx_ptr};
                OFS_RX_PTR: s_d.rdata = {17'h0, s_q.rx_ai, 3'h0, s_q.rx_ptr};
                OFS_QDATA: s_d.rdata = RXQ_RDATA;
                default: s_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_q.tx_ptr <= PTR_RESET;
            s_q.rx_ptr <= PTR_RESET;
            s_q.tx_ai <= AUTO_INC_RESET;
            s_q.rx_ai <= AUTO_INC_RESET;
            s_q.rdata <= '0;
            s_q.rxq_addr <= PTR_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // rx memory is addressed by the registered pointer
    assign RXQ_ADDR = s_q.rxq_addr;
    assign REG_RDATA = s_q.rdata;
    assign TX_ENQ_REQ = tx_req;
    assign RX_REL_REQ = rx_req;
    assign TXQ_STALL = ~buf_in_ready;

    // pointer stepping, holding and reload, where a host write wins over both; command bits held set, tx pointer reserved bits zero
    chk_tx_auto_step: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (wr_data && s_q.tx_ai && !wr_tx_ptr && !(tx_req && TX_ENQ_ACK) && REG_SIZE == 2'h1)
        |=> s_q.tx_ptr == PTR_W'($past(s_q.tx_ptr) + 11'h002))
        else $error("tx pointer did not step by two");
    chk_tx_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (!s_q.tx_ai && !wr_tx_ptr && !(tx_req && TX_ENQ_ACK)) |=> $stable(s_q.tx_ptr))
        else $error("tx pointer moved without cause");
    chk_rx_auto_step: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (rd_data && s_q.rx_ai && !wr_rx_ptr && !(rx_req && RX_REL_ACK) && REG_SIZE == 2'h0)
        |=> s_q.rx_ptr == PTR_W'($past(s_q.rx_ptr) + 11'h001))
        else $error("rx pointer did not step by one");
    chk_rx_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (!s_q.rx_ai && !wr_rx_ptr && !(rx_req && RX_REL_ACK)) |=> $stable(s_q.rx_ptr))
        else $error("rx pointer moved without cause");
    chk_tx_reload: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (tx_req && TX_ENQ_ACK && !wr_tx_ptr) |=> s_q.tx_ptr == $past(TX_NEXT_PTR))
        else $error("tx pointer not reloaded");
    chk_rx_reload: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (rx_req && RX_REL_ACK && !wr_rx_ptr) |=> s_q.rx_ptr == $past(RX_NEXT_PTR))
        else $error("rx pointer not reloaded");
    chk_enq_busy: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (wr_tx_enq && REG_WDATA[0] && !tx_busy) |=> tx_busy [*2])
        else $error("enqueue bit cleared early");
    chk_rel_busy: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (wr_rx_rel && REG_WDATA[0] && !rx_busy) |=> rx_busy ##0 RX_REL_REQ)
        else $error("release bit not set");
    chk_resv_zero: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (REG_RD && REG_ADDR == OFS_TX_PTR) |=> REG_RDATA[31:15] == 17'h0 && REG_RDATA[13:11] == 3'h0)
        else $error("reserved bits not zero");

    // command bits: start, request held to ack, self-clear only on done
    chk_enq_start: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (wr_tx_enq && REG_WDATA[CMD_BIT] && !tx_busy)
        |=> TX_ENQ_REQ && tx_busy)
        else $error("enqueue request not raised");
    chk_rel_start: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (wr_rx_rel && REG_WDATA[CMD_BIT] && !rx_busy)
        |=> RX_REL_REQ && rx_busy)
        else $error("release request not raised");
    chk_enq_zero_ign: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (wr_tx_enq && !REG_WDATA[CMD_BIT] && !tx_busy)
        |=> !tx_busy)
        else $error("zero write started an enqueue");
    chk_rel_zero_ign: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (wr_rx_rel && !REG_WDATA[CMD_BIT] && !rx_busy)
        |=> !rx_busy)
        else $error("zero write started a release");
    chk_enq_req_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (TX_ENQ_REQ && !TX_ENQ_ACK)
        |=> TX_ENQ_REQ)
        else $error("enqueue request dropped before ack");
    chk_rel_req_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (RX_REL_REQ && !RX_REL_ACK)
        |=> RX_REL_REQ)
        else $error("release request dropped before ack");
    chk_enq_wait: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (tx_busy && !TX_DONE)
        |=> tx_busy)
        else $error("enqueue bit cleared before done");
    chk_rel_wait: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (rx_busy && !RX_FREED)
        |=> rx_busy)
        else $error("release bit cleared before freed");
    chk_enq_clear: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (tx_busy && !TX_ENQ_REQ && TX_DONE)
        |=> !tx_busy)
        else $error("enqueue bit stuck after done");
    chk_rel_clear: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (rx_busy && !RX_REL_REQ && RX_FREED)
        |=> !rx_busy)
        else $error("release bit stuck after freed");

    // pointer writes and steps of the other sizes
    chk_tx_ptr_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        wr_tx_ptr
        |=> s_q.tx_ptr == PTR_W'($past(REG_WDATA)) && s_q.tx_ai == $past(REG_WDATA[AUTO_INC_BIT]))
        else $error("tx pointer write not taken");
    chk_rx_ptr_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        wr_rx_ptr
        |=> s_q.rx_ptr == PTR_W'($past(REG_WDATA)) && s_q.rx_ai == $past(REG_WDATA[AUTO_INC_BIT]))
        else $error("rx pointer write not taken");
    chk_tx_step_dword: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (wr_data && s_q.tx_ai && !wr_tx_ptr && !(tx_req && TX_ENQ_ACK) && REG_SIZE == 2'h2)
        |=> s_q.tx_ptr == PTR_W'($past(s_q.tx_ptr) + 11'h004))
        else $error("tx pointer did not step by four");
    chk_rx_step_word: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (rd_data && s_q.rx_ai && !wr_rx_ptr && !(rx_req && RX_REL_ACK) && REG_SIZE == 2'h1)
        |=> s_q.rx_ptr == PTR_W'($past(s_q.rx_ptr) + 11'h002))
        else $error("rx pointer did not step by two");

    // data accesses move only their own direction's pointer
    chk_tx_no_read: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (rd_data && !wr_tx_ptr && !(tx_req && TX_ENQ_ACK))
        |=> $stable(s_q.tx_ptr))
        else $error("data read moved tx pointer");
    chk_rx_no_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (wr_data && !wr_rx_ptr && !(rx_req && RX_REL_ACK))
        |=> $stable(s_q.rx_ptr))
        else $error("data write moved rx pointer");

    // read data: one cycle after the strobe, zero otherwise
    chk_qdata_read: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        rd_data
        |=> REG_RDATA == $past(RXQ_RDATA))
        else $error("queue data read wrong");
    chk_enq_readback: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (REG_RD && REG_ADDR == OFS_TX_ENQ)
        |=> REG_RDATA == {31'h0, $past(tx_busy)})
        else $error("enqueue bit read wrong");
    chk_rel_readback: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (REG_RD && REG_ADDR == OFS_RX_REL)
        |=> REG_RDATA == {31'h0, $past(rx_busy)})
        else $error("release bit read wrong");
    chk_rdata_idle: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        !REG_RD
        |=> REG_RDATA == 32'h0)
        else $error("read data not zero without a read");
    chk_rx_resv_zero: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (REG_RD && REG_ADDR == OFS_RX_PTR)
        |=> REG_RDATA[31:15] == 17'h0 && REG_RDATA[13:11] == 3'h0)
        else $error("rx reserved bits not zero");
endmodule

// >>> verif/hfqa_far_model.sv
// queue manager and queue memory model on the far side of the block
`timescale 1ns/10ps
module hfqa_qm_chan (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req,
    input wire logic [3:0] dly,
    output logic ack,
    output logic done
);
    logic ph;
    logic [3:0] cnt;
    // ack after dly idle cycles, done pulse dly+1 cycles after ack
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {ph, cnt, ack, done} <= '0;
        end else begin
            ack <= 1'b0;
            done <= 1'b0;
            cnt <= cnt + 4'h1;
            if (!ph && !req) begin
                cnt <= 4'h0;
            end
            if (cnt >= dly && (ph || (req && !ack))) begin
                ack <= !ph;
                done <= ph;
                ph <= !ph;
                cnt <= 4'h0;
            end
        end
    end
endmodule

module hfqa_far_model #(
    parameter logic [10:0] TX_NEXT = 11'h2a0,
    parameter logic [10:0] RX_NEXT = 11'h155
) (
    input wire logic clk,
    input wire logic rst_n,
    // stall and answer delay from the bench
    input wire logic hold,
    input wire logic [3:0] dly,
    // queue memories
    output logic txq_ready,
    input wire logic [10:0] rxq_addr,
    output logic [31:0] rxq_rdata,
    // frame handshakes
    input wire logic enq_req,
    output logic enq_ack,
    output logic tx_done,
    output logic [10:0] tx_next,
    input wire logic rel_req,
    output logic rel_ack,
    output logic rx_freed,
    output logic [10:0] rx_next
);
    // any access size taken; read data is a pattern of the address
    assign txq_ready = !hold;
    assign rxq_rdata = {10'h0, ~rxq_addr, rxq_addr};
    assign tx_next = TX_NEXT;
    assign rx_next = RX_NEXT;
    hfqa_qm_chan i_tx (.clk(clk), .rst_n(rst_n), .req(enq_req), .dly(dly), .ack(enq_ack), .done(tx_done));
    hfqa_qm_chan i_rx (.clk(clk), .rst_n(rst_n), .req(rel_req), .dly(dly), .ack(rel_ack), .done(rx_freed));
endmodule

// >>> verif/host_frame_queue_access_test.sv
// self-checking bench for the host frame queue access block
`timescale 1ns/10ps
module host_frame_queue_access_test;
    import hfqa_pkg::*;
    typedef struct packed {logic [3:0] a; logic [31:0] d; logic [15:0] e;} hfqa_row_type;
    logic CORE_CLK = 0, RST_N = 0, REG_WR = 0, REG_RD = 0, hold = 0;
    logic [3:0] REG_ADDR = 0, dly = 0;
    logic [31:0] REG_WDATA = 0, REG_RDATA, TXQ_DATA, RXQ_RDATA, rv;
    logic [1:0] REG_SIZE = 0, TXQ_SIZE;
    logic [10:0] TXQ_ADDR, RXQ_ADDR, TX_NEXT_PTR, RX_NEXT_PTR;
    logic TXQ_VALID, TXQ_READY, TXQ_STALL, TX_ENQ_REQ, TX_ENQ_ACK, TX_DONE, RX_REL_REQ, RX_REL_ACK, RX_FREED;
    logic [44:0] txlog[$];
    int miscompares = 0, num_checks = 0, cyc = 0, i;
    hfqa_row_type rows[6] = '{'{4'h4, 32'hffffffff, 16'h47ff}, '{4'h6, 32'hffffffff, 16'h47ff},
        '{4'h4, 32'h123, 16'h0123}, '{4'h6, 32'h456, 16'h0456},
        '{4'h0, 32'hfffffffe, 16'h0}, '{4'h2, 32'hfffffffe, 16'h0}};
    hfqa_top i_dut (.CORE_CLK, .RST_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_SIZE, .REG_RDATA,
        .TXQ_VALID, .TXQ_READY, .TXQ_ADDR, .TXQ_DATA, .TXQ_SIZE, .TXQ_STALL, .RXQ_ADDR, .RXQ_RDATA,
        .TX_ENQ_REQ, .TX_ENQ_ACK, .TX_DONE, .TX_NEXT_PTR, .RX_REL_REQ, .RX_REL_ACK, .RX_FREED, .RX_NEXT_PTR);
    hfqa_far_model i_far (.clk(CORE_CLK), .rst_n(RST_N), .hold(hold), .dly(dly), .txq_ready(TXQ_READY),
        .rxq_addr(RXQ_ADDR), .rxq_rdata(RXQ_RDATA), .enq_req(TX_ENQ_REQ), .enq_ack(TX_ENQ_ACK),
        .tx_done(TX_DONE), .tx_next(TX_NEXT_PTR), .rel_req(RX_REL_REQ), .rel_ack(RX_REL_ACK),
        .rx_freed(RX_FREED), .rx_next(RX_NEXT_PTR));
    // 25 MHz clock
    initial begin
        forever #20 CORE_CLK = ~CORE_CLK;
    end
    // log of words the tx queue accepted; timeout ceiling
    always @(posedge CORE_CLK) begin
        if (TXQ_VALID === 1'b1 && TXQ_READY === 1'b1) begin
            txlog.push_back({TXQ_SIZE, TXQ_ADDR, TXQ_DATA});
        end
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            report_and_stop();
        end
    end
    function automatic logic [31:0] pat(input logic [10:0] a);
        return {10'h0, ~a, a};
    endfunction
    task report_and_stop;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task chk(input logic [44:0] g, input logic [44:0] e);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // bus cycles: strobes change only by nba after a rising edge
    task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] s);
        @(posedge CORE_CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_SIZE <= s;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [1:0] s);
        @(posedge CORE_CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        REG_SIZE <= s;
        @(posedge CORE_CLK);
        REG_RD <= 1'b0;
        #1 rv = REG_RDATA;
    endtask
    task chk_reg(input logic [3:0] a, input logic [1:0] s, input logic [31:0] e);
        rd(a, s);
        chk({13'h0, rv}, {13'h0, e});
    endtask
    task chk_tx(input logic [44:0] e);
        logic [44:0] g;
        g = 'x;
        if (txlog.size() > 0) begin
            g = txlog.pop_front();
        end
        chk(g, e);
    endtask
    // polls a command bit under a bounded count, then expects it clear
    task wait_clr(input logic [3:0] a);
        for (int n = 0; n < 40; n++) begin
            rd(a, 2'h0);
            if (rv === 32'h0) begin
                break;
            end
        end
        chk_reg(a, 2'h0, 32'h0);
    endtask
    initial begin
        repeat (3) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        for (i = 0; i < 4; i++) begin
            chk_reg(4'(2 * i), 2'h0, 32'h0);
        end
        $display("test reset done");
        foreach (rows[k]) begin
            wr(rows[k].a, rows[k].d, 2'h2);
            chk_reg(rows[k].a, 2'h2, {16'h0, rows[k].e});
        end
        $display("test table done");
        // tx stepping by 1, 2, 4 across the wrap
        wr(OFS_TX_PTR, 32'h47fd, 2'h0);
        wr(OFS_QDATA, 32'h11, 2'h0);
        wr(OFS_QDATA, 32'h2222, 2'h1);
        wr(OFS_QDATA, 32'h33333333, 2'h2);
        chk_reg(OFS_TX_PTR, 2'h0, 32'h4004);
        chk_tx({2'h0, 11'h7fd, 32'h11});
        chk_tx({2'h1, 11'h7fe, 32'h2222});
        chk_tx({2'h2, 11'h000, 32'h33333333});
        wr(OFS_TX_PTR, 32'h10, 2'h0);
        wr(OFS_QDATA, 32'h44, 2'h2);
        chk_reg(OFS_TX_PTR, 2'h0, 32'h10);
        chk_tx({2'h2, 11'h010, 32'h44});
        $display("test tx pointer done");
        // far side stalls: two words held, third refused
        @(posedge CORE_CLK);
        hold <= 1'b1;
        for (i = 0; i < 3; i++) begin
            wr(OFS_QDATA, 32'ha + i, 2'h2);
        end
        #1 chk({44'h0, TXQ_STALL}, 45'h1);
        @(posedge CORE_CLK);
        hold <= 1'b0;
        repeat (4) @(posedge CORE_CLK);
        chk_tx({2'h2, 11'h010, 32'ha});
        chk_tx({2'h2, 11'h010, 32'hb});
        chk(45'(txlog.size()), 45'h0);
        $display("test stall done");
        // slow enqueue, quicker release
        dly <= 4'h4;
        wr(OFS_TX_ENQ, 32'h1, 2'h0);
        chk_reg(OFS_TX_ENQ, 2'h0, 32'h1);
        wait_clr(OFS_TX_ENQ);
        chk_reg(OFS_TX_PTR, 2'h0, 32'h2a0);
        dly <= 4'h1;
        wr(OFS_RX_REL, 32'h1, 2'h0);
        chk_reg(OFS_RX_REL, 2'h0, 32'h1);
        wait_clr(OFS_RX_REL);
        chk_reg(OFS_RX_PTR, 2'h0, 32'h155);
        $display("test commands done");
        // rx stepping on reads, then holding
        wr(OFS_RX_PTR, 32'h47ff, 2'h0);
        chk_reg(OFS_QDATA, 2'h0, pat(11'h7ff));
        chk_reg(OFS_QDATA, 2'h1, pat(11'h000));
        chk_reg(OFS_RX_PTR, 2'h0, 32'h4002);
        chk_reg(OFS_QDATA, 2'h3, pat(11'h002));
        chk_reg(OFS_RX_PTR, 2'h0, 32'h4006);
        wr(OFS_RX_PTR, 32'h5, 2'h0);
        chk_reg(OFS_QDATA, 2'h2, pat(11'h005));
        chk_reg(OFS_RX_PTR, 2'h0, 32'h5);
        $display("test rx pointer done");
        // second reset in mid-run
        @(posedge CORE_CLK);
        RST_N <= 1'b0;
        @(posedge CORE_CLK);
        RST_N <= 1'b1;
        chk_reg(OFS_RX_PTR, 2'h0, 32'h0);
        $display("test mid reset done");
        report_and_stop();
    end
endmodule
